// ### hdl/crjt_test_port.v
// boundary-scan test port: tap controller, instruction decode, data registers
`timescale 1ns/100ps
`include "crjt_defs.vh"
module crjt_test_port #(
  parameter BSR_W = 4,                 // boundary cells: one per pin; under external test each captures pin_in and drives pin_out
  parameter [31:0] ID_CODE = 32'h0000_1ABD, // arbitrary identification value
  parameter [31:0] USER_CODE_INIT = 32'hFFFF_FFFF
) (
  input wire clock,                    // system clock
  input wire rst_b,                    // async reset, active low
  input wire clk_en,                   // freezes all state while low
  input wire tck,                      // test clock pin
  input wire tms,                      // test mode select pin
  input wire tdi,                      // test data in pin
  input wire trst_b,                   // optional test reset pin, active low
  input wire [BSR_W-1:0] pin_in,       // levels at the device pins
  input wire [BSR_W-1:0] core_out,     // values the core wants at the pins
  output reg [BSR_W-1:0] pin_out,      // values driven at the pins
  output reg tdo,                      // test data out
  output reg tdo_oe,                   // tdo driven, only in shift states
  output reg config_start_out_n,       // open-drain output level, always 0
  output reg config_start_oe,          // high while pulling start line low
  output reg isp_erase,                // pulse: erase request to the flash store
  output reg isp_write,                // pulse: program word in isp_data
  output reg [`CRJT_ISP_W-1:0] isp_data // address and data of isp request
);
  localparam RESET = 4'h0;
  localparam IDLE = 4'h1;
  localparam SEL_DR = 4'h2;
  localparam CAP_DR = 4'h3;
  localparam SH_DR = 4'h4;
  localparam EX1_DR = 4'h5;
  localparam PAU_DR = 4'h6;
  localparam EX2_DR = 4'h7;
  localparam UPD_DR = 4'h8;
  localparam SEL_IR = 4'h9;
  localparam CAP_IR = 4'hA;
  localparam SH_IR = 4'hB;
  localparam EX1_IR = 4'hC;
  localparam PAU_IR = 4'hD;
  localparam EX2_IR = 4'hE;
  localparam UPD_IR = 4'hF;
  localparam IR_W = `CRJT_IR_W;
  localparam ISP_W = `CRJT_ISP_W;

  // pins cross into the clock domain through two flops each; first flop read only by second
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg tck_d;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      // idle-high values, so a parked high tck gives no false rise after reset
      sync1 <= 4'hF;
      sync2 <= 4'hF;
      tck_d <= 1'b1;
    end else if (clk_en) begin
      sync1 <= {trst_b, tdi, tms, tck};
      sync2 <= sync1;
      tck_d <= sync2[0];
    end
  end
  wire s_tck = sync2[0];
  wire s_tms = sync2[1];
  wire s_tdi = sync2[2];
  wire s_trst_b = sync2[3];
  wire tck_rise = clk_en && s_tck && !tck_d;
  wire tck_fall = clk_en && !s_tck && tck_d;

  reg [3:0] state;
  reg [3:0] next_state;
  always @* begin
    case (state)
      RESET: next_state = s_tms ? RESET : IDLE;
      IDLE: next_state = s_tms ? SEL_DR : IDLE;
      SEL_DR: next_state = s_tms ? SEL_IR : CAP_DR;
      CAP_DR: next_state = s_tms ? EX1_DR : SH_DR;
      SH_DR: next_state = s_tms ? EX1_DR : SH_DR;
      EX1_DR: next_state = s_tms ? UPD_DR : PAU_DR;
      PAU_DR: next_state = s_tms ? EX2_DR : PAU_DR;
      EX2_DR: next_state = s_tms ? UPD_DR : SH_DR;
      UPD_DR: next_state = s_tms ? SEL_DR : IDLE;
      SEL_IR: next_state = s_tms ? RESET : CAP_IR;
      CAP_IR: next_state = s_tms ? EX1_IR : SH_IR;
      SH_IR: next_state = s_tms ? EX1_IR : SH_IR;
      EX1_IR: next_state = s_tms ? UPD_IR : PAU_IR;
      PAU_IR: next_state = s_tms ? EX2_IR : PAU_IR;
      EX2_IR: next_state = s_tms ? UPD_IR : SH_IR;
      UPD_IR: next_state = s_tms ? SEL_DR : IDLE;
      default: next_state = RESET;
    endcase
  end

  reg [IR_W-1:0] ir_sh;
  reg [IR_W-1:0] ir;
  reg [BSR_W-1:0] bsr_sh;
  reg [BSR_W-1:0] bsr_upd;
  reg [31:0] code_sh;
  reg [31:0] user_code;
  reg [ISP_W-1:0] isp_sh;
  reg bypass_bit;

  wire sel_ext = (ir == `CRJT_OP_EXTEST);
  wire sel_bsr = sel_ext || (ir == `CRJT_OP_SAMPLE);
  wire sel_id = (ir == `CRJT_OP_IDCODE);
  wire sel_user = (ir == `CRJT_OP_USERCODE);
  wire sel_isp = (ir == `CRJT_OP_ISP_PROG) || (ir == `CRJT_OP_ISP_ERASE) ||
    (ir == `CRJT_OP_ISP_READ);
  wire is_shift = (state == SH_DR) || (state == SH_IR);

  // pin levels come from outside the clock domain; each cell gets its own flop pair
  wire [BSR_W-1:0] s_pin_in;
  genvar g;
  generate
    for (g = 0; g < BSR_W; g = g + 1) begin : g_pin
      reg pin_m;
      reg pin_s;
      always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          pin_m <= 1'b0;
          pin_s <= 1'b0;
        end else if (clk_en) begin
          pin_m <= pin_in[g];
          pin_s <= pin_m;
        end
      end
      assign s_pin_in[g] = pin_s;
    end
  endgenerate

  // boundary cells capture pin levels under external test and core outputs under sample/preload
  wire [BSR_W-1:0] cap_bsr = sel_ext ? s_pin_in : core_out;

  reg tdo_bit;
  always @* begin
    if (state == SH_IR)
      tdo_bit = ir_sh[0];
    else if (sel_bsr)
      tdo_bit = bsr_sh[0];
    else if (sel_id || sel_user)
      tdo_bit = code_sh[0];
    else if (sel_isp)
      tdo_bit = isp_sh[0];
    else
      tdo_bit = bypass_bit;
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= RESET;
      ir <= `CRJT_OP_IDCODE;
      ir_sh <= {IR_W{1'b0}};
      bsr_sh <= {BSR_W{1'b0}};
      bsr_upd <= {BSR_W{1'b0}};
      code_sh <= 32'h0000_0000;
      user_code <= USER_CODE_INIT;
      isp_sh <= {ISP_W{1'b0}};
      bypass_bit <= 1'b0;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      pin_out <= {BSR_W{1'b0}};
      config_start_out_n <= 1'b0;
      config_start_oe <= 1'b0;
      isp_erase <= 1'b0;
      isp_write <= 1'b0;
      isp_data <= {ISP_W{1'b0}};
    end else if (clk_en) begin
      isp_erase <= 1'b0;
      isp_write <= 1'b0;
      if (!s_trst_b) begin
        state <= RESET;
        ir <= `CRJT_OP_IDCODE;
      end else if (tck_rise) begin
        state <= next_state;
        case (state)
          RESET: ir <= `CRJT_OP_IDCODE;
          CAP_IR: ir_sh <= `CRJT_IR_CAPTURE;
          SH_IR: ir_sh <= {s_tdi, ir_sh[IR_W-1:1]};
          UPD_IR: ir <= ir_sh;
          CAP_DR: begin
            bypass_bit <= 1'b0;
            if (sel_bsr)
              bsr_sh <= cap_bsr;
            if (sel_id)
              code_sh <= ID_CODE;
            if (sel_user)
              code_sh <= user_code;
            if (sel_isp)
              isp_sh <= {isp_sh[ISP_W-1:32], user_code};
          end
          SH_DR: begin
            bypass_bit <= s_tdi;
            bsr_sh <= {s_tdi, bsr_sh[BSR_W-1:1]};
            code_sh <= {s_tdi, code_sh[31:1]};
            isp_sh <= {s_tdi, isp_sh[ISP_W-1:1]};
          end
          UPD_DR: begin
            if (sel_bsr)
              bsr_upd <= bsr_sh;
            // user code lives in the store, so a program word at address zero clears the user code bits that are zero in its data
            if (ir == `CRJT_OP_ISP_PROG) begin
              isp_write <= 1'b1;
              isp_data <= isp_sh;
              if (isp_sh[ISP_W-1:32] == {`CRJT_ISP_ADDR_W{1'b0}})
                user_code <= user_code & isp_sh[31:0];
            end
            if (ir == `CRJT_OP_ISP_ERASE) begin
              isp_erase <= 1'b1;
              user_code <= 32'hFFFF_FFFF;
            end
          end
          default: ;
        endcase
      end else if (tck_fall) begin
        tdo <= tdo_bit;
        tdo_oe <= is_shift;
      end
      // sample/preload never touches the pins; only external test drives the preloaded cells
      pin_out <= sel_ext ? bsr_upd : core_out;
      config_start_oe <= (ir == `CRJT_OP_START_CFG);
    end
  end
endmodule

// ### hdl/crjt_defs.vh
// constants for the configuration memory boundary-scan test port
`ifndef CRJT_DEFS_VH
`define CRJT_DEFS_VH
`define CRJT_IR_W 4
`define CRJT_OP_EXTEST 4'h0
`define CRJT_OP_SAMPLE 4'h1
`define CRJT_OP_IDCODE 4'h6
`define CRJT_OP_USERCODE 4'h7
`define CRJT_OP_START_CFG 4'hA
`define CRJT_OP_ISP_ERASE 4'hB
`define CRJT_OP_ISP_PROG 4'hC
`define CRJT_OP_ISP_READ 4'hD
`define CRJT_OP_BYPASS 4'hF
`define CRJT_IR_CAPTURE 4'h1
`define CRJT_ISP_W 40
`define CRJT_ISP_ADDR_W 8
`endif

// ### tb/crjt_jtag_host.sv
// jtag controller model that drives the four-wire test port
`timescale 1ns/100ps
module crjt_jtag_host (
  input wire clock, // sys clock
  input wire tdo, // test data out
  output logic tck, // test clock, still high between steps
  output logic tms, // mode select
  output logic tdi // data in
);
  initial {tck, tms, tdi} = 3'b111;
  // tck period is 8 clocks, tdo is read just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clock);
    {tck, tms, tdi} <= {1'b0, m, d};
    repeat (4) @(posedge clock);
    o = tdo;
    tck <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  // from idle: shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [39:0] v, output logic [39:0] q);
    logic o;
    q = '0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    repeat (2) step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], o);
      q[i] = o;
    end
    step(1'b1, !v[n-1], o); // released data line toggles
    step(1'b0, v[n-1], o);
    // the update lands two clocks after the last rise is seen; let outputs settle
    repeat (2) @(posedge clock);
  endtask
endmodule

// ### tb/crjt_test_port_props.sv
// assertions on the test port outputs
`timescale 1ns/100ps
module crjt_test_port_props (
  input wire clock, // sys clock
  input wire rst_b, // reset, active low
  input wire tck, // test clock
  input wire tdo, // test data out
  input wire tdo_oe, // tdo enable
  input wire config_start_out_n, // start level
  input wire config_start_oe, // start drive
  input wire isp_erase, // erase pulse
  input wire isp_write // program pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence wr_s; isp_write ##1 !isp_write; endsequence
  sequence er_s; isp_erase ##1 !isp_erase; endsequence
  start_low_a: assert property (config_start_oe |-> !config_start_out_n)
    else $error("start line high");
  start_rise_a: assert property ($rose(config_start_oe) |-> $past(tck, 2))
    else $error("start drive off update");
  start_fall_a: assert property ($fell(config_start_oe) |-> $past(tck, 2))
    else $error("start release off update");
  erase_pulse_a: assert property (isp_erase |-> er_s)
    else $error("erase pulse long");
  write_pulse_a: assert property (isp_write |-> wr_s)
    else $error("write pulse long");
  write_edge_a: assert property (isp_write |-> tck)
    else $error("write off update");
  tdo_edge_a: assert property (tdo_oe && $changed(tdo) |-> !tck)
    else $error("tdo moved on rise");
  shift_exit_a: assert property ($fell(tdo_oe) |-> !tck)
    else $error("tdo enable off edge");
endmodule
bind crjt_test_port crjt_test_port_props i_props (.clock(clock), .rst_b(rst_b), .tck(tck),
  .tdo(tdo), .tdo_oe(tdo_oe), .config_start_out_n(config_start_out_n),
  .config_start_oe(config_start_oe), .isp_erase(isp_erase), .isp_write(isp_write));

// ### tb/test_crjt_test_port.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
`include "crjt_defs.vh"
module test_crjt_test_port;
  logic clock = 1'b0, rst_b = 1'b0, o;
  logic [3:0] pin_in = 4'h9, core_out = 4'h5, pin_out;
  logic tck, tms, tdi, tdo, tdo_oe, csn, cs_oe, isp_erase, isp_write;
  logic [39:0] isp_data, q;
  int errors = 0, cmp_count = 0;
  int erase_cnt = 0, write_cnt = 0;
  always @(posedge clock) begin
    if (isp_erase === 1'b1) erase_cnt++;
    if (isp_write === 1'b1) write_cnt++;
  end
  crjt_test_port i_dut (.clock(clock), .rst_b(rst_b), .clk_en(1'b1), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_b(1'b1), .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out),
    .tdo(tdo), .tdo_oe(tdo_oe), .config_start_out_n(csn), .config_start_oe(cs_oe),
    .isp_erase(isp_erase), .isp_write(isp_write), .isp_data(isp_data));
  crjt_jtag_host i_host (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  initial forever #20 clock = ~clock;
  task chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task ir(input logic [3:0] op);
    i_host.scan(1'b1, 4, {36'h0, op}, q);
    chk(q[3:0], `CRJT_IR_CAPTURE);
  endtask
  task t_id;
    i_host.step(1'b0, 1'b0, o);
    ir(4'h3);
    i_host.scan(1'b0, 6, 40'h2D, q);
    chk(q[5:0], 6'h1A);
    repeat (5) i_host.step(1'b1, 1'b0, o);
    i_host.step(1'b0, 1'b0, o);
    i_host.scan(1'b0, 32, 40'h0, q);
    chk(q[31:0], 32'h0000_1ABD);
    $display("test id done");
  endtask
  task t_isp;
    ir(`CRJT_OP_ISP_PROG);
    i_host.scan(1'b0, 40, 40'h00_1234_5678, q);
    chk(isp_data, 40'h00_1234_5678);
    chk(write_cnt, 40'h1);
    ir(`CRJT_OP_USERCODE);
    i_host.scan(1'b0, 32, 40'h0, q);
    chk(q[31:0], 32'h1234_5678);
    ir(`CRJT_OP_ISP_READ);
    i_host.scan(1'b0, 40, 40'h0, q);
    chk(q[31:0], 32'h1234_5678);
    ir(`CRJT_OP_ISP_ERASE);
    i_host.scan(1'b0, 40, 40'h0, q);
    chk(erase_cnt, 40'h1);
    ir(`CRJT_OP_USERCODE);
    i_host.scan(1'b0, 32, 40'h0, q);
    chk(q[31:0], 32'hFFFF_FFFF);
    $display("test isp done");
  endtask
  task t_bsr;
    ir(`CRJT_OP_SAMPLE);
    i_host.scan(1'b0, 4, 40'hA, q);
    chk(q[3:0], core_out);
    chk(pin_out, core_out);
    ir(`CRJT_OP_EXTEST);
    chk(pin_out[1:0], 2'h2);
    i_host.scan(1'b0, 4, 40'h1, q);
    chk(q[3:0], pin_in);
    chk(pin_out[1:0], 2'h1);
    $display("test bsr done");
  endtask
  task t_start;
    ir(`CRJT_OP_START_CFG);
    chk({cs_oe, csn}, 2'b10);
    ir(`CRJT_OP_IDCODE);
    chk({cs_oe, csn}, 2'b00);
    $display("test start done");
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_id;
    t_isp;
    t_bsr;
    t_start;
    test_done;
  end
  // about 400 tck steps of 320 ns are expected
  initial begin
    #1000000;
    errors++;
    test_done;
  end
endmodule
